/* File: pss_pkg.sv */
// shared constants of the pump safety supervisor and its controller
package pss_pkg;
    // clock and time base
    localparam int unsigned CLK_KHZ        = 25000;
    localparam int unsigned US_PER_MS      = 1000;
    localparam int unsigned CNT_W          = 32;
    // processor watchdog
    localparam int unsigned WD_TIMEOUT_MS  = 1000;
    localparam int unsigned WD_CYCLES      = CLK_KHZ * WD_TIMEOUT_MS;
    localparam int unsigned RST_PULSE_US   = 10;
    localparam int unsigned RST_CYCLES     = (CLK_KHZ * RST_PULSE_US + US_PER_MS - 1) / US_PER_MS;
    // motor run limit and half-turn check
    localparam int unsigned MOTOR_LIMIT_MS = 4000;
    localparam int unsigned MOTOR_CYCLES   = CLK_KHZ * MOTOR_LIMIT_MS;
    localparam int unsigned CAM_WAIT_MS    = 5000;
    localparam int unsigned CAM_CYCLES     = CLK_KHZ * CAM_WAIT_MS;
    // alarm tones
    localparam int unsigned LO_TONE_HZ     = 1000;
    localparam int unsigned HI_TONE_HZ     = 2000;
    localparam int unsigned LO_HALF_CYCLES = CLK_KHZ * US_PER_MS / (2 * LO_TONE_HZ);
    localparam int unsigned HI_HALF_CYCLES = CLK_KHZ * US_PER_MS / (2 * HI_TONE_HZ);
    localparam int unsigned WARBLE_HALF_MS = 400;
    localparam int unsigned WARBLE_CYCLES  = CLK_KHZ * WARBLE_HALF_MS;
    // register map of the controller
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STROBE     = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_INT_STAT   = 8'h0C;
    localparam logic [7:0]  OFS_INT_CLR    = 8'h10;
    localparam logic [7:0]  OFS_INT_EN     = 8'h14;
    // control bits
    localparam int unsigned CTRL_RUN       = 0;
    localparam int unsigned CTRL_TEST      = 1;
    localparam int unsigned CTRL_LO        = 2;
    localparam int unsigned CTRL_HI        = 3;
    localparam int unsigned CTRL_FLAG      = 4;
    // status bits
    localparam int unsigned ST_EXPIRED     = 0;
    localparam int unsigned ST_TIMEOUT     = 1;
    localparam int unsigned ST_CAM         = 2;
    localparam int unsigned ST_FAULT       = 3;
    localparam int unsigned ST_WAIT        = 4;
    // interrupt events
    localparam int unsigned INT_W          = 4;
    localparam int unsigned EV_BAD_RESET   = 0;
    localparam int unsigned EV_MOTOR_TO    = 1;
    localparam int unsigned EV_CAM_LATE    = 2;
    localparam int unsigned EV_CAM_STRAY   = 3;
endpackage

/* File: pss_if.sv */
// link between the pump processor side and the safety supervisor
`timescale 1ns/100ps
interface pss_if;
    logic wd_strobe;
    logic motor_run;
    logic motor_test;
    logic alarm_lo;
    logic alarm_hi;
    logic cpu_reset;
    logic wd_expired;
    logic motor_timeout;
    logic cam_flag;

    modport dev (
        input  wd_strobe, motor_run, motor_test, alarm_lo, alarm_hi,
        output cpu_reset, wd_expired, motor_timeout, cam_flag
    );
    modport host (
        output wd_strobe, motor_run, motor_test, alarm_lo, alarm_hi,
        input  cpu_reset, wd_expired, motor_timeout, cam_flag
    );
endinterface

/* File: pss_tone.sv */
// alarm tone generator: low, high or warble square wave
`timescale 1ns/100ps
module pss_tone #(
    parameter int unsigned LO_HALF = pss_pkg::LO_HALF_CYCLES,
    parameter int unsigned HI_HALF = pss_pkg::HI_HALF_CYCLES,
    parameter int unsigned WARBLE  = pss_pkg::WARBLE_CYCLES
) (
    // system
    input  wire logic clk,
    input  wire logic rst_n,
    // tone selects
    input  wire logic sel_lo,
    input  wire logic sel_hi,
    // piezo drive
    output logic      tone
);
    typedef struct packed {
        logic [pss_pkg::CNT_W-1:0] half_cnt;
        logic [pss_pkg::CNT_W-1:0] warb_cnt;
        logic                      phase_hi;
        logic                      tone;
    } pss_tone_state_type;

    pss_tone_state_type s_reg;
    pss_tone_state_type s_next;
    logic               use_hi;
    logic [pss_pkg::CNT_W-1:0] half;

    always_comb begin
        s_next = s_reg;
        use_hi = 1'b0;
        half   = pss_pkg::CNT_W'(LO_HALF);
        if (!(sel_lo || sel_hi)) begin
            s_next = '0;
        end else begin
            // both selects: swap tones every warble half period
            if (sel_lo && sel_hi) begin //RQ12
                use_hi = s_reg.phase_hi;
                if (s_reg.warb_cnt >= pss_pkg::CNT_W'(WARBLE - 1)) begin
                    s_next.warb_cnt = '0;
                    s_next.phase_hi = ~s_reg.phase_hi;
                end else begin
                    s_next.warb_cnt = s_reg.warb_cnt + 1'b1;
                end
            end else begin
                use_hi = sel_hi; //RQ12
            end
            if (use_hi) begin
                half = pss_pkg::CNT_W'(HI_HALF);
            end
            if (s_reg.half_cnt >= half - 1'b1) begin
                s_next.half_cnt = '0;
                s_next.tone     = ~s_reg.tone;
            end else begin
                s_next.half_cnt = s_reg.half_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tone = s_reg.tone;
endmodule

/* File: pss_device.sv */
// pump safety supervisor: processor watchdog, motor run watchdog, alarm
// Contract
// [RQ1] strobe each second or watchdog resets
// [RQ2] timeout cuts motor and sounds alarm
// [RQ3] reset output is a single pulse
// [RQ4] processor tests watchdog at every power-up
// [RQ5] unexpected reset: latch, alarm, error message
// [RQ6] motor cut after four seconds running
// [RQ7] no motor run while watchdog expired
// [RQ8] test lines check run timer without motor
// [RQ9] position light on only while motor runs
// [RQ10] half turn within five seconds, then stop
// [RQ11] rotation without run command is fault
// [RQ12] low, high or warble tone selection
// [RQ13] low battery and timeout also enable alarm
// [RQ14] run timer clears when motor off
// [RQ15] watchdog restarts on strobe and pulse
`timescale 1ns/100ps
module pss_device #(
    parameter int unsigned WD_CYCLES    = pss_pkg::WD_CYCLES,
    parameter int unsigned RST_CYCLES   = pss_pkg::RST_CYCLES,
    parameter int unsigned MOTOR_CYCLES = pss_pkg::MOTOR_CYCLES,
    parameter int unsigned LO_HALF      = pss_pkg::LO_HALF_CYCLES,
    parameter int unsigned HI_HALF      = pss_pkg::HI_HALF_CYCLES,
    parameter int unsigned WARBLE       = pss_pkg::WARBLE_CYCLES
) (
    // system
    input  wire logic clk,
    input  wire logic rst_n,
    // processor link
    pss_if.dev        link,
    // pump hardware
    input  wire logic low_batt,
    input  wire logic cam_sensor,
    output logic      motor_drive,
    output logic      ir_led_on,
    output logic      alarm_en,
    output logic      tone_out
);
    typedef struct packed {
        logic [pss_pkg::CNT_W-1:0] wd_cnt;
        logic [pss_pkg::CNT_W-1:0] rst_cnt;
        logic [pss_pkg::CNT_W-1:0] run_cnt;
        logic                      expired;
        logic                      rst_out;
        logic                      timeout;
        logic                      drive;
        logic                      led;
        logic                      alarm;
        logic                      tone_lo;
        logic                      tone_hi;
        logic                      cam;
    } pss_dev_state_type;

    pss_dev_state_type s_reg;
    pss_dev_state_type s_next;
    logic              timing;
    logic              hw_alarm;

    always_comb begin
        s_next     = s_reg;
        s_next.cam = cam_sensor;

        // processor watchdog
        if (s_reg.rst_out) begin
            s_next.wd_cnt = '0; //RQ15
            if (s_reg.rst_cnt >= pss_pkg::CNT_W'(RST_CYCLES - 1)) begin
                s_next.rst_out = 1'b0; //RQ3
                s_next.rst_cnt = '0;
            end else begin
                s_next.rst_cnt = s_reg.rst_cnt + 1'b1;
            end
        end else if (link.wd_strobe) begin
            s_next.wd_cnt  = '0; //RQ15
            s_next.expired = 1'b0;
        end else if (s_reg.wd_cnt >= pss_pkg::CNT_W'(WD_CYCLES - 1)) begin
            s_next.wd_cnt  = '0; //RQ1
            s_next.expired = 1'b1;
            s_next.rst_out = 1'b1; //RQ3
        end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
        end

        // motor run timer, also run by the test line without driving
        timing = link.motor_run || link.motor_test;
        if (!timing) begin
            s_next.run_cnt = '0; //RQ14
            s_next.timeout = 1'b0;
        end else if (s_reg.run_cnt >= pss_pkg::CNT_W'(MOTOR_CYCLES - 1)) begin
            s_next.timeout = 1'b1; //RQ6
        end else begin
            s_next.run_cnt = s_reg.run_cnt + 1'b1; //RQ8
        end

        // drive refused on run timeout, test mode or expired watchdog
        s_next.drive = link.motor_run && !link.motor_test //RQ8
            && !s_next.timeout && !s_next.expired; //RQ2 RQ6 RQ7
        s_next.led   = s_next.drive; //RQ9

        // alarm: processor selects, low battery, watchdog expiry
        hw_alarm       = low_batt || s_next.expired; //RQ13 RQ2
        s_next.tone_lo = link.alarm_lo || hw_alarm;
        s_next.tone_hi = link.alarm_hi || hw_alarm;
        s_next.alarm   = s_next.tone_lo || s_next.tone_hi; //RQ13
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    pss_tone #(
        .LO_HALF (LO_HALF),
        .HI_HALF (HI_HALF),
        .WARBLE  (WARBLE)
    ) u_tone (
        .clk    (clk),
        .rst_n  (rst_n),
        .sel_lo (s_reg.tone_lo),
        .sel_hi (s_reg.tone_hi),
        .tone   (tone_out)
    );

    assign motor_drive        = s_reg.drive;
    assign ir_led_on          = s_reg.led;
    assign alarm_en           = s_reg.alarm;
    assign link.cpu_reset     = s_reg.rst_out;
    assign link.wd_expired    = s_reg.expired;
    assign link.motor_timeout = s_reg.timeout;
    assign link.cam_flag      = s_reg.cam;
endmodule

/* File: pss_host.sv */
// pump processor end: APB registers, strobe, motor and cam checks, interrupt
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module pss_host #(
    parameter int unsigned CAM_CYCLES = pss_pkg::CAM_CYCLES
) (
    // system
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // supervisor link
    pss_if.host                               link,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [pss_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [pss_pkg::DATA_W-1:0]   pwdata,
    output logic      [pss_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    // interrupt
    output logic                              irq
);
    typedef struct packed {
        logic [4:0]                ctrl;
        logic                      strobe;
        logic                      fault;
        logic                      wait_cam;
        logic [pss_pkg::CNT_W-1:0] cam_cnt;
        logic                      cam_prev;
        logic                      to_prev;
        logic                      rst_prev;
        logic [pss_pkg::INT_W-1:0] int_stat;
        logic [pss_pkg::INT_W-1:0] int_en;
        logic [pss_pkg::DATA_W-1:0] rdata;
        logic                      ready;
        logic                      err;
        logic                      irq;
    } pss_host_state_type;

    pss_host_state_type         s_reg;
    pss_host_state_type         s_next;
    logic                       acc;
    logic                       wr;
    logic                       cam_edge;
    logic [pss_pkg::INT_W-1:0]  ev;
    logic [pss_pkg::INT_W-1:0]  clr;

    always_comb begin
        s_next        = s_reg;
        ev            = '0;
        clr           = '0;
        s_next.strobe = 1'b0;
        s_next.ready  = 1'b0;
        s_next.err    = 1'b0;
        acc           = psel && penable && s_reg.ready;
        wr            = acc && pwrite;

        // one wait state, then answer
        if (psel && penable && !s_reg.ready) begin
            s_next.ready = 1'b1;
            s_next.rdata = '0;
            case (paddr)
                pss_pkg::OFS_CTRL: s_next.rdata[4:0] = s_reg.ctrl;
                pss_pkg::OFS_STATUS: begin
                    s_next.rdata[pss_pkg::ST_EXPIRED] = link.wd_expired;
                    s_next.rdata[pss_pkg::ST_TIMEOUT] = link.motor_timeout;
                    s_next.rdata[pss_pkg::ST_CAM]     = link.cam_flag;
                    s_next.rdata[pss_pkg::ST_FAULT]   = s_reg.fault;
                    s_next.rdata[pss_pkg::ST_WAIT]    = s_reg.wait_cam;
                end
                pss_pkg::OFS_INT_STAT: s_next.rdata[pss_pkg::INT_W-1:0] = s_reg.int_stat;
                pss_pkg::OFS_INT_EN: s_next.rdata[pss_pkg::INT_W-1:0] = s_reg.int_en;
                pss_pkg::OFS_STROBE, pss_pkg::OFS_INT_CLR: s_next.rdata = '0;
                default: s_next.err = 1'b1;
            endcase
        end

        if (wr) begin
            case (paddr)
                pss_pkg::OFS_CTRL: begin
                    // run rising starts the half-turn check
                    if (pwdata[pss_pkg::CTRL_RUN] && !s_reg.ctrl[pss_pkg::CTRL_RUN]) begin
                        s_next.wait_cam = 1'b1; //RQ10
                        s_next.cam_cnt  = '0;
                    end
                    s_next.ctrl = pwdata[4:0]; //RQ8 RQ4
                end
                pss_pkg::OFS_STROBE: s_next.strobe = 1'b1; //RQ1
                pss_pkg::OFS_INT_CLR: clr = pwdata[pss_pkg::INT_W-1:0];
                pss_pkg::OFS_INT_EN: s_next.int_en = pwdata[pss_pkg::INT_W-1:0];
                default: s_next.err = 1'b0;
            endcase
        end

        // camshaft checks
        s_next.cam_prev = link.cam_flag;
        cam_edge        = link.cam_flag != s_reg.cam_prev;
        if (s_reg.wait_cam) begin
            if (cam_edge) begin
                s_next.wait_cam = 1'b0; //RQ10
                s_next.ctrl[pss_pkg::CTRL_RUN] = 1'b0;
            end else if (s_reg.cam_cnt >= pss_pkg::CNT_W'(CAM_CYCLES - 1)) begin
                s_next.wait_cam = 1'b0;
                s_next.ctrl[pss_pkg::CTRL_RUN] = 1'b0;
                ev[pss_pkg::EV_CAM_LATE] = 1'b1; //RQ10
            end else begin
                s_next.cam_cnt = s_reg.cam_cnt + 1'b1;
            end
        end else if (cam_edge && !s_reg.ctrl[pss_pkg::CTRL_RUN]) begin
            ev[pss_pkg::EV_CAM_STRAY] = 1'b1; //RQ11
        end

        s_next.to_prev = link.motor_timeout;
        ev[pss_pkg::EV_MOTOR_TO] = link.motor_timeout && !s_reg.to_prev;

        // watchdog reset: judged once at pulse start, test flag says expected
        s_next.rst_prev = link.cpu_reset;
        if (link.cpu_reset) begin
            s_next.ctrl[pss_pkg::CTRL_RUN] = 1'b0;
            s_next.wait_cam = 1'b0;
            if (!s_reg.rst_prev && s_reg.ctrl[pss_pkg::CTRL_FLAG]) begin
                s_next.ctrl[pss_pkg::CTRL_FLAG] = 1'b0; //RQ4
            end else if (!s_reg.rst_prev) begin
                ev[pss_pkg::EV_BAD_RESET] = 1'b1; //RQ5
            end
        end

        s_next.fault = (s_reg.fault && !clr[pss_pkg::EV_BAD_RESET]) || ev[pss_pkg::EV_BAD_RESET]; //RQ5
        s_next.int_stat = (s_reg.int_stat & ~clr) | ev;
        s_next.irq      = |(s_next.int_stat & s_next.int_en);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata          = s_reg.rdata;
    assign pready          = s_reg.ready;
    assign pslverr         = s_reg.err;
    assign irq             = s_reg.irq;
    assign link.wd_strobe  = s_reg.strobe;
    assign link.motor_run  = s_reg.ctrl[pss_pkg::CTRL_RUN];
    assign link.motor_test = s_reg.ctrl[pss_pkg::CTRL_TEST];
    assign link.alarm_lo   = s_reg.ctrl[pss_pkg::CTRL_LO] || s_reg.fault; //RQ5
    assign link.alarm_hi   = s_reg.ctrl[pss_pkg::CTRL_HI] || s_reg.fault;
endmodule

/* File: pss_asserts.sv */
// link checks for the pump safety supervisor
`timescale 1ns/100ps
module pss_asserts #(
    parameter int unsigned WD_CYCLES    = pss_pkg::WD_CYCLES,
    parameter int unsigned RST_CYCLES   = pss_pkg::RST_CYCLES,
    parameter int unsigned MOTOR_CYCLES = pss_pkg::MOTOR_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // host to device
    input wire logic wd_strobe,
    input wire logic motor_run,
    input wire logic motor_test,
    input wire logic alarm_lo,
    input wire logic alarm_hi,
    // device to host
    input wire logic cpu_reset,
    input wire logic wd_expired,
    input wire logic motor_timeout,
    input wire logic cam_flag
);
    logic [31:0] idle_reg;
    logic [31:0] pulse_reg;
    logic [31:0] run_reg;

    // idle, pulse and run lengths
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_reg  <= 32'h0;
            pulse_reg <= 32'h0;
            run_reg   <= 32'h0;
        end else begin
            idle_reg  <= (wd_strobe || cpu_reset) ? 32'h0 : idle_reg + 32'h1;
            pulse_reg <= cpu_reset ? pulse_reg + 32'h1 : 32'h0;
            run_reg   <= (motor_run || motor_test) ? run_reg + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_pulse_len;
        $fell(cpu_reset) |-> pulse_reg == RST_CYCLES;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
    property p_pulse_max;
        cpu_reset |-> pulse_reg < RST_CYCLES;
    endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("reset pulse held too long");
    property p_expire_rst;
        $rose(cpu_reset) |-> wd_expired;
    endproperty
    a_expire_rst: assert property (p_expire_rst) else $error("reset pulse without expiry");
    property p_strobe_clr;
        wd_strobe && !cpu_reset |=> !wd_expired;
    endproperty
    a_strobe_clr: assert property (p_strobe_clr) else $error("strobe did not clear expiry");
    property p_expired_hold;
        wd_expired && !wd_strobe |=> wd_expired;
    endproperty
    a_expired_hold: assert property (p_expired_hold) else $error("expiry dropped without strobe");
    property p_wd_window;
        $rose(cpu_reset) |-> idle_reg >= WD_CYCLES - 2 && idle_reg <= WD_CYCLES + 1;
    endproperty
    a_wd_window: assert property (p_wd_window) else $error("watchdog fired at wrong time");
    property p_wd_bound;
        idle_reg <= WD_CYCLES + 1;
    endproperty
    a_wd_bound: assert property (p_wd_bound) else $error("watchdog failed to fire");
    property p_motor_window;
        $rose(motor_timeout) |-> run_reg >= MOTOR_CYCLES - 1 && run_reg <= MOTOR_CYCLES + 1;
    endproperty
    a_motor_window: assert property (p_motor_window) else $error("run timer fired at wrong time");
    property p_timer_clr;
        !motor_run && !motor_test |=> !motor_timeout;
    endproperty
    a_timer_clr: assert property (p_timer_clr) else $error("run timer not cleared");
endmodule

/* File: pump_safety_supervisor_tb.sv */
// self-checking bench for the pump safety supervisor
`timescale 1ns/100ps
module pump_safety_supervisor_tb;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdat;
        logic [31:0] exp;
        logic        err;
    } pss_row_type;
    localparam int unsigned WD = 200;
    localparam int unsigned RC = 4;
    localparam int unsigned MC = 300;
    localparam int unsigned LH = 8;
    localparam int unsigned HH = 4;
    logic        clk, rst_n, low_batt, cam_sensor, psel, penable, pwrite, pready, pslverr, irq;
    logic        motor_drive, ir_led_on, alarm_en, tone_out, err, slo, shi, drive_seen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    pss_row_type rows [10];

    pss_if pss_if_i ();
    pss_device #(.WD_CYCLES(WD), .RST_CYCLES(RC), .MOTOR_CYCLES(MC), .LO_HALF(LH), .HI_HALF(HH), .WARBLE(40))
    pss_device_i (.clk(clk), .rst_n(rst_n), .link(pss_if_i), .low_batt(low_batt), .cam_sensor(cam_sensor),
                  .motor_drive(motor_drive), .ir_led_on(ir_led_on), .alarm_en(alarm_en), .tone_out(tone_out));
    pss_host #(.CAM_CYCLES(200))
    pss_host_i (.clk(clk), .rst_n(rst_n), .link(pss_if_i), .psel(psel), .penable(penable), .pwrite(pwrite),
                .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    pss_asserts #(.WD_CYCLES(WD), .RST_CYCLES(RC), .MOTOR_CYCLES(MC))
    pss_asserts_i (.clk(clk), .rst_n(rst_n), .wd_strobe(pss_if_i.wd_strobe), .motor_run(pss_if_i.motor_run),
                   .motor_test(pss_if_i.motor_test), .alarm_lo(pss_if_i.alarm_lo), .alarm_hi(pss_if_i.alarm_hi),
                   .cpu_reset(pss_if_i.cpu_reset), .wd_expired(pss_if_i.wd_expired),
                   .motor_timeout(pss_if_i.motor_timeout), .cam_flag(pss_if_i.cam_flag));

    always #20 clk = ~clk;

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic strobe();
        apb(1'h1, pss_pkg::OFS_STROBE, 32'h0);
    endtask

    // strobe every 94 cycles, note motor drive
    task automatic keep_alive(input int n);
        repeat (n) begin
            strobe();
            repeat (90) begin
                @(posedge clk);
                drive_seen |= motor_drive;
            end
        end
        strobe();
    endtask

    // tone run lengths, first partial run skipped
    task automatic tone_runs(input int n);
        int   run;
        logic last;
        slo  = 1'h0;
        shi  = 1'h0;
        run  = -1000;
        last = tone_out;
        repeat (n) begin
            @(posedge clk);
            if (tone_out !== last) begin
                if (run == LH) slo = 1'h1;
                if (run == HH) shi = 1'h1;
                run  = 0;
                last = tone_out;
            end
            run++;
        end
    endtask

    task automatic wait_rst();
        int k = 0;
        while (pss_if_i.cpu_reset !== 1'h1 && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk_bit(pss_if_i.cpu_reset, 1'h1, "no watchdog reset");
    endtask

    initial begin
        clk = 1'h0; rst_n = 1'h0; low_batt = 1'h0; cam_sensor = 1'h0; drive_seen = 1'h0;
        psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00; pwdata = 32'h0;
        rows = '{'{1'h1, pss_pkg::OFS_CTRL, 32'h0000000C, 32'h0, 1'h0},
                 '{1'h0, pss_pkg::OFS_CTRL, 32'h0, 32'h0000000C, 1'h0},
                 '{1'h1, pss_pkg::OFS_INT_EN, 32'h0000000F, 32'h0, 1'h0},
                 '{1'h0, pss_pkg::OFS_INT_EN, 32'h0, 32'h0000000F, 1'h0},
                 '{1'h1, pss_pkg::OFS_STATUS, 32'h0000001F, 32'h0, 1'h0},
                 '{1'h0, pss_pkg::OFS_STATUS, 32'h0, 32'h0, 1'h0},
                 '{1'h0, pss_pkg::OFS_STROBE, 32'h0, 32'h0, 1'h0},
                 '{1'h1, 8'h18, 32'hFFFFFFFF, 32'h0, 1'h1},
                 '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1},
                 '{1'h0, pss_pkg::OFS_INT_STAT, 32'h0, 32'h0, 1'h0}};
        repeat (20) @(posedge clk);
        chk_bit(motor_drive, 1'h0, "drive in reset");
        chk_bit(alarm_en, 1'h0, "alarm in reset");
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdat);
            if (!rows[i].wr) chk_word(rd, rows[i].exp, "register read");
            chk_bit(err, rows[i].err, "slave error");
        end
        for (int m = 1; m < 4; m++) begin
            apb(1'h1, pss_pkg::OFS_CTRL, 32'(m) << 2);
            strobe();
            tone_runs(120);
            chk_bit(alarm_en, 1'h1, "alarm enable");
            chk_bit(slo, m[0], "low tone");
            chk_bit(shi, m[1], "high tone");
        end
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk_bit(alarm_en, 1'h0, "alarm off");
        low_batt <= 1'h1;
        strobe();
        tone_runs(100);
        chk_bit(alarm_en, 1'h1, "low battery alarm");
        chk_bit(slo & shi, 1'h1, "low battery warble");
        low_batt <= 1'h0;
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h2);
        keep_alive(4);
        chk_bit(drive_seen, 1'h0, "motor driven in test");
        chk_bit(pss_if_i.motor_timeout, 1'h1, "run timer expiry");
        chk_bit(pss_if_i.wd_expired, 1'h0, "expiry despite strobes");
        apb(1'h0, pss_pkg::OFS_INT_STAT, 32'h0);
        chk_word(rd, 32'h2, "timer event");
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk_bit(pss_if_i.motor_timeout, 1'h0, "timer clear");
        apb(1'h1, pss_pkg::OFS_INT_CLR, 32'hF);
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        chk_bit(motor_drive & ir_led_on, 1'h1, "motor and light on");
        repeat (30) @(posedge clk);
        cam_sensor <= 1'h1;
        repeat (5) @(posedge clk);
        chk_bit(motor_drive | ir_led_on, 1'h0, "stop at half turn");
        cam_sensor <= 1'h0;
        repeat (5) @(posedge clk);
        apb(1'h0, pss_pkg::OFS_INT_STAT, 32'h0);
        chk_word(rd, 32'h8, "stray rotation");
        apb(1'h1, pss_pkg::OFS_INT_CLR, 32'hF);
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h1);
        keep_alive(3);
        apb(1'h0, pss_pkg::OFS_INT_STAT, 32'h0);
        chk_word(rd, 32'h4, "late half turn");
        apb(1'h1, pss_pkg::OFS_INT_CLR, 32'hF);
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h11);
        wait_rst();
        repeat (2) @(posedge clk);
        chk_bit(alarm_en, 1'h1, "alarm on expiry");
        chk_bit(motor_drive, 1'h0, "motor on expiry");
        repeat (RC + 2) @(posedge clk);
        chk_bit(pss_if_i.cpu_reset, 1'h0, "pulse not ended");
        apb(1'h0, pss_pkg::OFS_CTRL, 32'h0);
        chk_word(rd, 32'h0, "test flag");
        apb(1'h0, pss_pkg::OFS_STATUS, 32'h0);
        chk_bit(rd[3], 1'h0, "test fault");
        apb(1'h1, pss_pkg::OFS_INT_CLR, 32'hF);
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        chk_bit(motor_drive, 1'h0, "motor while expired");
        strobe();
        repeat (3) @(posedge clk);
        chk_bit(pss_if_i.wd_expired, 1'h0, "expiry kept");
        chk_bit(motor_drive, 1'h1, "motor after strobe");
        apb(1'h1, pss_pkg::OFS_CTRL, 32'h0);
        apb(1'h1, pss_pkg::OFS_INT_EN, 32'h1);
        wait_rst();
        repeat (RC + 3) @(posedge clk);
        chk_bit(pss_if_i.alarm_lo & pss_if_i.alarm_hi, 1'h1, "fault alarm");
        chk_bit(irq, 1'h1, "fault interrupt");
        apb(1'h0, pss_pkg::OFS_STATUS, 32'h0);
        chk_bit(rd[3], 1'h1, "fault latch");
        apb(1'h1, pss_pkg::OFS_INT_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'h0, "masked interrupt");
        strobe();
        apb(1'h1, pss_pkg::OFS_INT_CLR, 32'hF);
        apb(1'h0, pss_pkg::OFS_INT_STAT, 32'h0);
        chk_word(rd, 32'h0, "cleared status");
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk_bit(alarm_en | motor_drive | irq, 1'h0, "outputs after reset");
        give_verdict();
    end
endmodule
